// file: logic/spi_port.v
`timescale 1ns/1ps
`include "spi_port_regs.vh"
module spi_port (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  output reg        irq_o,
  input  wire       sck_i,
  output reg        sck_o,
  output reg        sck_oe_o,
  input  wire       mosi_i,
  output reg        mosi_o,
  output reg        mosi_oe_o,
  input  wire       miso_i,
  output reg        miso_o,
  output reg        miso_oe_o,
  input  wire       nss_i,
  output reg        nss_o,
  output reg        nss_oe_o,
  output reg        nss_routed_o
);
  reg  [7:0] ctrl_q;
  reg  [7:0] div_q;
  reg  [7:0] shift_q;
  reg  [7:0] txbuf_q;
  reg        txfull_q;
  reg        shfull_q;
  reg  [7:0] rxbuf_q;
  reg  [3:0] bitcnt_q;
  reg        busy_q;
  reg        phase_q;
  reg        sck_int_q;
  reg        sin_q;
  reg  [`IRQ_BITS-1:0] stat_q;
  reg  [`IRQ_BITS-1:0] ien_q;
  reg        sck_prev_q;
  reg        nss_prev_q;
  wire [3:0] pins_s;
  wire       sck_s;
  wire       mosi_s;
  wire       nss_s;
  wire       miso_s;
  wire       tick;
  wire       enable    = ctrl_q[`CTRL_ENABLE];
  wire       master    = ctrl_q[`CTRL_MASTER];
  wire       cpol      = ctrl_q[`CTRL_CPOL];
  wire       cpha      = ctrl_q[`CTRL_CPHA];
  wire [1:0] sel_mode  = {ctrl_q[`CTRL_SEL_HI], ctrl_q[`CTRL_SEL_LO]};
  wire       wr_ctrl   = wr_i && (addr_i == `ADDR_CTRL);
  wire       wr_data   = wr_i && (addr_i == `ADDR_DATA);
  wire       wr_clr    = wr_i && (addr_i == `ADDR_IRQ_CLEAR);

  // pins come from another domain: two flops before use
  sync_2ff #(.WIDTH(4)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({sck_i, mosi_i, nss_i, miso_i}),
    .q_o    (pins_s)
  );
  assign sck_s  = pins_s[3];
  assign mosi_s = pins_s[2];
  assign nss_s  = pins_s[1];
  assign miso_s = pins_s[0];

  spi_clk_gen u_clk (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (busy_q && master),
    .div_i  (div_q),
    .tick_o (tick)
  );

  wire selected = (sel_mode == `SEL_3WIRE) ? 1'b1 : !nss_s;
  wire slave_on = enable && !master;
  // clock edges only count while selected
  wire sck_rise = slave_on && selected && sck_s && !sck_prev_q;
  wire sck_fall = slave_on && selected && !sck_s && sck_prev_q;
  wire lead     = cpol ? sck_fall : sck_rise;
  wire trail    = cpol ? sck_rise : sck_fall;
  wire s_sample = cpha ? trail : lead;
  wire s_shift  = cpha ? lead : trail;
  // falling select edge restarts the bit count
  wire nss_fall = (sel_mode == `SEL_4WIRE_IN) && nss_prev_q && !nss_s;
  // multi-master: falling select drops master function
  wire mode_fault = enable && master && nss_fall;
  wire m_sample = master && busy_q && tick && (phase_q == cpha);
  wire m_shift  = master && busy_q && tick && (phase_q != cpha);
  wire m_lastb  = master && busy_q && tick && phase_q && (bitcnt_q == `BITS_PER_BYTE);
  wire m_done   = m_lastb;
  wire s_done   = s_sample && (bitcnt_q == `BITS_PER_BYTE - 4'h1);
  wire done_ev  = m_done || s_done;
  wire ovr_ev   = done_ev && stat_q[`IRQ_DONE];
  wire [`IRQ_BITS-1:0] ev = {ovr_ev, mode_fault, done_ev};

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_prev_q <= 1'b0;
      // matches the synchroniser's reset level, so no false select edge
      nss_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      nss_prev_q <= nss_s;
    end
  end

  // control and config registers
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= `CTRL_RESET;
      div_q  <= `CLKDIV_RESET;
      ien_q  <= {`IRQ_BITS{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_i;
      end else if (mode_fault) begin
        ctrl_q[`CTRL_MASTER] <= 1'b0;
      end
      if (wr_i && (addr_i == `ADDR_CLKDIV)) begin
        div_q <= wdata_i;
      end
      if (wr_i && (addr_i == `ADDR_IRQ_ENABLE)) begin
        ien_q <= wdata_i[`IRQ_BITS-1:0];
      end
    end
  end

  // sticky status: set wins over clear
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= {`IRQ_BITS{1'b0}};
      irq_o  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(wr_clr ? wdata_i[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}})) | ev;
      irq_o  <= |(stat_q & ien_q);
    end
  end

  // shift engine, both roles
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q   <= 8'h00;
      txbuf_q   <= 8'h00;
      txfull_q  <= 1'b0;
      shfull_q  <= 1'b0;
      rxbuf_q   <= 8'h00;
      bitcnt_q  <= 4'h0;
      busy_q    <= 1'b0;
      phase_q   <= 1'b0;
      sck_int_q <= 1'b0;
      sin_q     <= 1'b0;
    end else begin
      if (wr_data) begin
        txbuf_q  <= wdata_i;
        txfull_q <= 1'b1;
      end
      if (!enable || mode_fault) begin
        busy_q    <= 1'b0;
        bitcnt_q  <= 4'h0;
        phase_q   <= 1'b0;
        sck_int_q <= cpol;
      end else if (master) begin
        if (!busy_q) begin
          sck_int_q <= cpol;
          if (txfull_q && !wr_data) begin
            shift_q  <= txbuf_q;
            txfull_q <= 1'b0;
            busy_q   <= 1'b1;
            bitcnt_q <= 4'h0;
            phase_q  <= 1'b0;
          end
        end else if (tick) begin
          phase_q   <= !phase_q;
          sck_int_q <= (m_lastb) ? cpol : !sck_int_q;
          if (m_sample) begin
            sin_q    <= miso_s;
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          if (m_shift && (bitcnt_q != 4'h0 || cpha)) begin
            shift_q <= {shift_q[6:0], sin_q};
          end
          if (m_lastb) begin
            busy_q  <= 1'b0;
            rxbuf_q <= {shift_q[6:0], sin_q};
          end
        end
      end else begin
        if (nss_fall) begin
          bitcnt_q <= 4'h0;
        end else if (s_sample) begin
          // external master's clock moves our data
          sin_q    <= mosi_s;
          bitcnt_q <= (bitcnt_q == `BITS_PER_BYTE - 4'h1) ? 4'h0 : bitcnt_q + 4'h1;
        end
        if (s_done) begin
          rxbuf_q  <= {shift_q[6:0], mosi_s};
          shfull_q <= 1'b0;
        end
        if (s_shift && !(bitcnt_q == 4'h0 && !cpha)) begin
          shift_q <= {shift_q[6:0], sin_q};
        end
        if (!shfull_q && txfull_q && !wr_data && bitcnt_q == 4'h0 && !s_sample) begin
          shift_q  <= txbuf_q;
          txfull_q <= 1'b0;
          shfull_q <= 1'b1;
        end
      end
    end
  end

  // pin drivers, all registered
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_o        <= 1'b0;
      sck_oe_o     <= 1'b0;
      mosi_o       <= 1'b0;
      mosi_oe_o    <= 1'b0;
      miso_o       <= 1'b0;
      miso_oe_o    <= 1'b0;
      nss_o        <= 1'b1;
      nss_oe_o     <= 1'b0;
      nss_routed_o <= 1'b0;
      rdata_o      <= 8'h00;
    end else begin
      // clock pin driven only as master
      sck_o     <= sck_int_q;
      sck_oe_o  <= enable && master && !mode_fault;
      mosi_o    <= shift_q[7];
      mosi_oe_o <= enable && master && !mode_fault;
      // slave drives master-in from shift msb
      miso_o    <= shift_q[7];
      // high impedance when off or unselected
      miso_oe_o <= slave_on && selected;
      // select output level is lower mode bit
      // follows the control write next cycle
      nss_o     <= wr_ctrl ? wdata_i[`CTRL_SEL_LO] : ctrl_q[`CTRL_SEL_LO];
      nss_oe_o  <= wr_ctrl ? (wdata_i[`CTRL_ENABLE] && wdata_i[`CTRL_SEL_HI])
                           : (enable && sel_mode[1]);
      // mode 01 routes it as an input
      nss_routed_o <= wr_ctrl ? (wdata_i[`CTRL_SEL_HI:`CTRL_SEL_LO] != `SEL_3WIRE)
                              : (sel_mode != `SEL_3WIRE);
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `ADDR_CTRL:       rdata_o <= ctrl_q;
          `ADDR_DATA:       rdata_o <= rxbuf_q;
          `ADDR_CLKDIV:     rdata_o <= div_q;
          `ADDR_IRQ_STATUS: rdata_o <= {busy_q, txfull_q, 3'h0, stat_q};
          `ADDR_IRQ_ENABLE: rdata_o <= {5'h00, ien_q};
          default:          rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

// file: logic/spi_port_regs.vh
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

`define ADDR_CTRL        4'h0
`define ADDR_DATA        4'h1
`define ADDR_CLKDIV      4'h2
`define ADDR_IRQ_STATUS  4'h3
`define ADDR_IRQ_ENABLE  4'h4
`define ADDR_IRQ_CLEAR   4'h5

`define CTRL_ENABLE      0
`define CTRL_MASTER      1
`define CTRL_SEL_LO      2
`define CTRL_SEL_HI      3
`define CTRL_CPOL        4
`define CTRL_CPHA        5
`define CTRL_RESET       8'h04
`define CLKDIV_RESET     8'h04

`define IRQ_DONE         0
`define IRQ_MODEFAULT    1
`define IRQ_OVERRUN      2
`define IRQ_BITS         3

`define SEL_3WIRE        2'h0
`define SEL_4WIRE_IN     2'h1

`define BITS_PER_BYTE    4'h8
`define NSS_SETUP_CLKS   2

`endif

// file: logic/sync_2ff.v
`timescale 1ns/1ps
module sync_2ff #(
  parameter WIDTH = 3
) (
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule

// file: logic/spi_clk_gen.v
`timescale 1ns/1ps
`include "spi_port_regs.vh"
module spi_clk_gen (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire       run_i,
  input  wire [7:0] div_i,
  output reg        tick_o
);
  reg [7:0] cnt_q;
  // tick every div_i+1 clocks while a master byte runs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else if (cnt_q >= div_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

// file: tb/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model (
  input  wire sck_o,
  input  wire sck_oe_o,
  input  wire mosi_o,
  input  wire mosi_oe_o,
  input  wire miso_o,
  input  wire miso_oe_o,
  output wire sck_w,
  output wire mosi_w,
  output wire miso_w,
  output reg  nss_w
);
  reg       m_sck  = 1'b0;
  reg       m_mosi = 1'b0;
  reg       m_drv  = 1'b0;
  reg       lm     = 1'b0;
  reg       ls     = 1'b0;
  reg [7:0] s_tx   = 8'h00;
  reg [7:0] s_rx   = 8'h00;
  initial nss_w = 1'b1;
  // released lines have no pull: show the inverse of the last level
  always @(mosi_o or m_mosi) lm = mosi_oe_o ? mosi_o : m_mosi;
  always @(miso_o or s_tx) ls = miso_oe_o ? miso_o : s_tx[7];
  assign sck_w  = sck_oe_o ? sck_o : m_sck;
  assign mosi_w = mosi_oe_o ? mosi_o : (m_drv ? m_mosi : ~lm);
  assign miso_w = miso_oe_o ? miso_o : (sck_oe_o ? s_tx[7] : ~ls);
  always @(posedge sck_w) if (sck_oe_o) s_rx <= {s_rx[6:0], mosi_w};
  always @(negedge sck_w) if (sck_oe_o) s_tx <= {s_tx[6:0], 1'b0};
  task xfer(input [7:0] tx, input sel, output [7:0] rx);
    integer i;
    begin
      #37;
      nss_w = ~sel;
      m_drv = 1'b1;
      // select well ahead of first edge
      #400;
      for (i = 7; i >= 0; i = i - 1) begin
        m_mosi = tx[i];
        #400 m_sck = 1'b1;
        rx = {rx[6:0], miso_w};
        #400 m_sck = 1'b0;
      end
      #400 nss_w = 1'b1;
      m_drv = 1'b0;
    end
  endtask
endmodule

// file: tb/spi_port_checker.sv
`timescale 1ns/1ps
module spi_port_checker (
  input wire       clk_i,
  input wire       rstn_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       sck_oe_o,
  input wire       mosi_oe_o,
  input wire       miso_oe_o,
  input wire       nss_i,
  input wire       nss_o,
  input wire       nss_oe_o,
  input wire       nss_routed_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire cw = wr_i && (addr_i == 4'h0);
  property p_lvl; cw |=> nss_o == $past(wdata_i[2]); endproperty
  a_lvl: assert property (p_lvl) else $error("select level");
  property p_soe; cw |=> nss_oe_o == ($past(wdata_i[3]) && $past(wdata_i[0])); endproperty
  a_soe: assert property (p_soe) else $error("select enable");
  property p_rte; cw |=> nss_routed_o == ($past(wdata_i[3:2]) != 2'b00); endproperty
  a_rte: assert property (p_rte) else $error("select routing");
  property p_mst; sck_oe_o |-> mosi_oe_o && !miso_oe_o; endproperty
  a_mst: assert property (p_mst) else $error("master pins");
  property p_on; cw && wdata_i[1:0] == 2'b11 |-> ##[1:3] sck_oe_o; endproperty
  a_on: assert property (p_on) else $error("no serial clock");
  property p_off; cw && !wdata_i[0] |-> ##[1:3] !(miso_oe_o || sck_oe_o); endproperty
  a_off: assert property (p_off) else $error("driving while off");
  property p_uns; (nss_routed_o && !nss_oe_o && nss_i) [*4] |-> !miso_oe_o; endproperty
  a_uns: assert property (p_uns) else $error("unselected drive");
  property p_3w; cw && wdata_i[3:0] == 4'h1 |-> ##[1:3] miso_oe_o; endproperty
  a_3w: assert property (p_3w) else $error("3-wire slave idle");
  property p_flt; sck_oe_o && nss_routed_o && !nss_oe_o && $fell(nss_i) |-> ##[1:6] !sck_oe_o;
  endproperty
  a_flt: assert property (p_flt) else $error("master kept");
endmodule
bind spi_port spi_port_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o),
  .miso_oe_o(miso_oe_o), .nss_i(nss_i), .nss_o(nss_o), .nss_oe_o(nss_oe_o),
  .nss_routed_o(nss_routed_o));

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  reg        clk_i       = 1'b0;
  reg        rstn_i      = 1'b0;
  reg  [3:0] addr_i      = 4'h0;
  reg  [7:0] wdata_i     = 8'h00;
  reg        wr_i        = 1'b0;
  reg        rd_i        = 1'b0;
  reg  [7:0] d;
  reg  [7:0] rx;
  integer    fails       = 0;
  integer    comparisons = 0;
  wire [7:0] rdata_o;
  wire       irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  wire       nss_o, nss_oe_o, nss_routed_o, sck_w, mosi_w, miso_w, nss_w;
  wire       nss_pin     = nss_oe_o ? nss_o : nss_w;
  always #50 clk_i = ~clk_i;
  spi_port u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .nss_i(nss_pin), .nss_o(nss_o), .nss_oe_o(nss_oe_o), .nss_routed_o(nss_routed_o));
  spi_peer_model u_peer (.sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .sck_w(sck_w),
    .mosi_w(mosi_w), .miso_w(miso_w), .nss_w(nss_w));
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] v);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
    end
  endtask
  task rc(input [3:0] a, input [7:0] e);
    begin
      rd(a, d);
      `CHK(d, e)
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc(4'h0, 8'h04);
    rc(4'hF, 8'h00);
    `CHK({nss_o, nss_routed_o, miso_oe_o, sck_oe_o}, 4'hC)
    $display("reset test done");
    wr(4'h0, 8'h05);
    wr(4'h1, 8'hA5);
    wr(4'h4, 8'h01);
    settle(4);
    `CHK(miso_oe_o, 1'b0)
    u_peer.xfer(8'h3C, 1'b1, rx);
    `CHK(rx, 8'hA5)
    rc(4'h1, 8'h3C);
    `CHK(irq_o, 1'b1)
    wr(4'h5, 8'h07);
    settle(2);
    `CHK(irq_o, 1'b0)
    u_peer.xfer(8'hFF, 1'b0, rx);
    rd(4'h3, d);
    `CHK(d[0], 1'b0)
    $display("4-wire slave test done");
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h96);
    settle(3);
    `CHK({nss_routed_o, miso_oe_o}, 2'b01)
    u_peer.xfer(8'h69, 1'b0, rx);
    `CHK(rx, 8'h96)
    `CHK(irq_o, 1'b0)
    rc(4'h1, 8'h69);
    $display("3-wire slave test done");
    wr(4'h5, 8'h07);
    wr(4'h2, 8'h03);
    u_peer.s_tx = 8'hC3;
    // select output driven whenever enabled with upper mode bit set
    wr(4'h0, 8'h0B);
    settle(1);
    `CHK({nss_o, nss_oe_o, nss_routed_o}, 3'b011)
    wr(4'h1, 8'h5A);
    d = 8'h00;
    for (int n = 0; n < 100 && d[0] !== 1'b1; n++) rd(4'h3, d);
    `CHK(d[0], 1'b1)
    if (d[0] !== 1'b1) complete_run;
    `CHK(u_peer.s_rx, 8'h5A)
    rc(4'h1, 8'hC3);
    wr(4'h0, 8'h0F);
    settle(1);
    `CHK(nss_o, 1'b1)
    $display("master test done");
    wr(4'h5, 8'h07);
    wr(4'h0, 8'h07);
    settle(2);
    `CHK(sck_oe_o, 1'b1)
    u_peer.nss_w = 1'b0;
    settle(8);
    `CHK(sck_oe_o, 1'b0)
    rd(4'h3, d);
    `CHK(d[1], 1'b1)
    u_peer.nss_w = 1'b1;
    wr(4'h0, 8'h00);
    settle(3);
    `CHK({miso_oe_o, sck_oe_o, mosi_oe_o}, 3'b000)
    $display("mode fault test done");
    complete_run;
  end
endmodule
